// ---- design/jpo_defs.svh ----
// register offsets, field positions and reset values of the jog pulse block
`ifndef JPO_DEFS_SVH
`define JPO_DEFS_SVH
`define JPO_ADR_CTRL      8'h00
`define JPO_ADR_STATE     8'h04
`define JPO_ADR_IRQ_STAT  8'h08
`define JPO_ADR_IRQ_MASK  8'h0c
`define JPO_ADR_POS_LO    8'h10
`define JPO_ADR_POS_HI    8'h14
`define JPO_ADR_HALF      8'h18
`define JPO_CTRL_MODE     0
`define JPO_CTRL_CLR_ABN  1
`define JPO_CTRL_W        2
`define JPO_ST_ABN        0
`define JPO_ST_BUSY       1
`define JPO_ST_DIR        2
`define JPO_EV_LIMIT      0
`define JPO_EV_RELEASE    1
`define JPO_EV_W          2
`define JPO_HALF_W        16
`define JPO_HALF_RST      16'h0004
`define JPO_HALF_ONE      16'h0001
`define JPO_POS_W         32
`define JPO_WORD_W        16
`define JPO_POS_RST       32'h0000_0000
`define JPO_POS_STEP      32'h0000_0001
`define JPO_DAT_W         32
`define JPO_ADR_W         8
`define JPO_SEL_W         4
`endif

// ---- design/jpo_pkg.sv ----
// types shared by the jog pulse block
`default_nettype none
package jpo_pkg;
  // one classic wishbone request as driven by the master
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  sel;
    logic [7:0]  adr;
    logic [31:0] dat;
  } jpo_wb_req_t;

  typedef enum logic [1:0] {
    JPO_IDLE,
    JPO_FWD,
    JPO_REV
  } jpo_state_t;
endpackage : jpo_pkg
`default_nettype wire

// ---- design/jpo_pulse_gen.sv ----
// square pulse train generator with one step strobe per rising edge
`include "jpo_defs.svh"
`default_nettype none
module jpo_pulse_gen (
  input  wire logic                   core_clk_in,
  input  wire logic                   rst_in,
  input  wire logic                   en_in,
  input  wire logic [`JPO_HALF_W-1:0] half_in,
  output var  logic                   level_out,
  output var  logic                   step_out
);
  logic [`JPO_HALF_W-1:0] cnt_r;
  logic [`JPO_HALF_W-1:0] reload;

  // a zero half period would underflow, so it runs as one cycle
  assign reload = (half_in == '0) ? '0 : half_in - `JPO_HALF_ONE;

  // level drops at once when disabled so no partial pulse lingers
  always_ff @(posedge core_clk_in) begin
    if (rst_in || !en_in) begin
      cnt_r     <= '0;
      level_out <= 1'b0;
    end else if (cnt_r == '0) begin
      cnt_r     <= reload;
      level_out <= ~level_out;
    end else begin
      cnt_r <= cnt_r - `JPO_HALF_ONE;
    end
  end

  // one strobe for each pulse emitted, never while disabled
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      step_out <= 1'b0;
    end else begin
      step_out <= en_in && (cnt_r == '0) && !level_out;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  toggle_when_due_a: assert property (en_in && cnt_r == '0 ##1 en_in
                                      |-> level_out != $past(level_out))
    else $error("pulse level did not toggle when due");
  no_pulse_idle_a: assert property (!en_in |=> !level_out && !step_out)
    else $error("pulse activity while disabled");
endmodule : jpo_pulse_gen
`default_nettype wire

// ---- design/jpo_top.sv ----
// jog mode pulse output controller with wishbone register slave
// What this block does
// - limit inputs are normally closed: low means the limit is hit
// - jog inputs are normally open: high only while the switch is held
// - forward runs only with forward jog high, both limits high, reverse low
// - pulse plus direction mode: pulse toggles, direction high in forward
// - separate mode forward: forward pulse toggles, reverse pulse stays low
// - each forward pulse adds one to the 32-bit position count
// - forward jog release stops pulses; direction stays high afterwards
// - position count holds once pulses have stopped
// - forward limit low during forward motion stops it like a release
// - a limit stop sets the readable abnormal end flag
// - position reads as two 16-bit words, lower word first
// - reverse counts down, direction low, separate mode toggles reverse pulse
//
// Our own choices: the address map and the Wishbone register port.
`include "jpo_defs.svh"
`default_nettype none
module jpo_top (
  input  wire logic                  core_clk_in,
  input  wire logic                  rst_in,
  input  wire jpo_pkg::jpo_wb_req_t  wb_req_in,
  output var  logic [`JPO_DAT_W-1:0] wb_dat_out,
  output var  logic                  wb_ack_out,
  input  wire logic                  fwd_limit_in,
  input  wire logic                  rev_limit_in,
  input  wire logic                  jog_fwd_in,
  input  wire logic                  jog_rev_in,
  output var  logic                  pulse_train_out,
  output var  logic                  direction_out,
  output var  logic                  adapter_pulse_out,
  output var  logic                  adapter_dir_out,
  output var  logic                  abnormal_end_flag_out,
  output var  logic                  irq_out
);
  jpo_pkg::jpo_state_t    state_r;
  jpo_pkg::jpo_state_t    state_nxt;
  logic [`JPO_CTRL_W-1:0] ctrl_r;
  logic [`JPO_EV_W-1:0]   irq_stat_r;
  logic [`JPO_EV_W-1:0]   irq_stat_nxt;
  logic [`JPO_EV_W-1:0]   irq_mask_r;
  logic [`JPO_EV_W-1:0]   events;
  logic [`JPO_HALF_W-1:0] half_r;
  logic [`JPO_POS_W-1:0]  pos_r;
  logic [`JPO_DAT_W-1:0]  rd_mux;
  logic [`JPO_DAT_W-1:0]  wmask;
  logic [`JPO_DAT_W-1:0]  wdat;
  logic                   dir_r;
  logic                   abn_r;
  logic                   abn_nxt;
  logic                   fwd_ok;
  logic                   rev_ok;
  logic                   limits_clear;
  logic                   limit_stop;
  logic                   release_stop;
  logic                   start;
  logic                   level;
  logic                   step;
  logic                   sep_mode;
  logic                   bus_req;
  logic                   bus_wr;
  logic                   bus_rd;
  logic                   clr_abn;

  // limits are closed contacts: a high level means free to move
  assign limits_clear = fwd_limit_in && rev_limit_in;
  // jog inputs are open contacts, so high means the switch is held
  assign fwd_ok = jog_fwd_in && limits_clear && !jog_rev_in;
  assign rev_ok = jog_rev_in && limits_clear && !jog_fwd_in;
  assign start  = (state_r == jpo_pkg::JPO_IDLE) && (fwd_ok || rev_ok);
  assign sep_mode = ctrl_r[`JPO_CTRL_MODE];

  // a stop with the jog still held is a limit stop only if a limit is open; the other jog with both limits closed makes it a release
  always_comb begin
    limit_stop   = 1'b0;
    release_stop = 1'b0;
    case (state_r)
      jpo_pkg::JPO_FWD: begin
        limit_stop   = !fwd_ok && jog_fwd_in && !limits_clear;
        release_stop = !fwd_ok && !limit_stop;
      end
      jpo_pkg::JPO_REV: begin
        limit_stop   = !rev_ok && jog_rev_in && !limits_clear;
        release_stop = !rev_ok && !limit_stop;
      end
      default: begin
        limit_stop   = 1'b0;
        release_stop = 1'b0;
      end
    endcase
  end

  // motion state: any loss of the run condition returns to idle
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      jpo_pkg::JPO_IDLE: begin
        if (fwd_ok) begin
          state_nxt = jpo_pkg::JPO_FWD;
        end else if (rev_ok) begin
          state_nxt = jpo_pkg::JPO_REV;
        end
      end
      jpo_pkg::JPO_FWD: begin
        if (!fwd_ok) begin
          state_nxt = jpo_pkg::JPO_IDLE;
        end
      end
      jpo_pkg::JPO_REV: begin
        if (!rev_ok) begin
          state_nxt = jpo_pkg::JPO_IDLE;
        end
      end
      default: begin
        state_nxt = jpo_pkg::JPO_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state_r <= jpo_pkg::JPO_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // direction latches on a start and is kept after the stop
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      dir_r <= 1'b0;
    end else if (start && fwd_ok) begin
      dir_r <= 1'b1;
    end else if (start) begin
      dir_r <= 1'b0;
    end
  end

  jpo_pulse_gen u_pulse (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .en_in       (state_r != jpo_pkg::JPO_IDLE),
    .half_in     (half_r),
    .level_out   (level),
    .step_out    (step)
  );

  // pin outputs are registered so the drive never glitches
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pulse_train_out   <= 1'b0;
      direction_out     <= 1'b0;
      adapter_pulse_out <= 1'b0;
      adapter_dir_out   <= 1'b0;
    end else if (sep_mode) begin
      pulse_train_out   <= level && dir_r;
      direction_out     <= level && !dir_r;
      adapter_pulse_out <= level && dir_r;
      adapter_dir_out   <= level && !dir_r;
    end else begin
      pulse_train_out   <= level;
      direction_out     <= dir_r;
      adapter_pulse_out <= level;
      adapter_dir_out   <= dir_r;
    end
  end

  // count moves only on a step strobe, so it freezes with the pulses
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      pos_r <= `JPO_POS_RST;
    end else if (step && dir_r) begin
      pos_r <= pos_r + `JPO_POS_STEP;
    end else if (step) begin
      pos_r <= pos_r - `JPO_POS_STEP;
    end
  end

  // bus decode: one word per register, answered one cycle later
  assign bus_req = wb_req_in.cyc && wb_req_in.stb && !wb_ack_out;
  assign bus_wr  = bus_req && wb_req_in.we;
  assign bus_rd  = bus_req && !wb_req_in.we;

  // byte enables widen to a bit mask for partial writes
  for (genvar i = 0; i < `JPO_SEL_W; i++) begin : g_lane
    assign wmask[8*i +: 8] = {8{wb_req_in.sel[i]}};
  end
  assign wdat    = wb_req_in.dat & wmask;
  assign clr_abn = bus_wr && (wb_req_in.adr == `JPO_ADR_CTRL)
                   && wdat[`JPO_CTRL_CLR_ABN];

  always_comb begin
    rd_mux = '0;
    case (wb_req_in.adr)
      `JPO_ADR_CTRL:     rd_mux[`JPO_CTRL_MODE] = ctrl_r[`JPO_CTRL_MODE];
      `JPO_ADR_STATE: begin
        rd_mux[`JPO_ST_ABN]  = abn_r;
        rd_mux[`JPO_ST_BUSY] = (state_r != jpo_pkg::JPO_IDLE);
        rd_mux[`JPO_ST_DIR]  = dir_r;
      end
      `JPO_ADR_IRQ_STAT: rd_mux[`JPO_EV_W-1:0] = irq_stat_r;
      `JPO_ADR_IRQ_MASK: rd_mux[`JPO_EV_W-1:0] = irq_mask_r;
      `JPO_ADR_POS_LO:   rd_mux[`JPO_WORD_W-1:0] = pos_r[`JPO_WORD_W-1:0];
      `JPO_ADR_POS_HI:   rd_mux[`JPO_WORD_W-1:0] = pos_r[`JPO_POS_W-1:`JPO_WORD_W];
      `JPO_ADR_HALF:     rd_mux[`JPO_HALF_W-1:0] = half_r;
      default:           rd_mux = '0;
    endcase
  end

  // ack for every address, unmapped ones read zero and ignore writes
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= '0;
    end else begin
      wb_ack_out <= bus_req;
      wb_dat_out <= bus_rd ? rd_mux : '0;
    end
  end

  // writable registers; clear bit of ctrl is a strobe, never stored
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      ctrl_r     <= '0;
      irq_mask_r <= '0;
      half_r     <= `JPO_HALF_RST;
    end else if (bus_wr) begin
      if (wb_req_in.adr == `JPO_ADR_CTRL && wb_req_in.sel[0]) begin
        ctrl_r[`JPO_CTRL_MODE] <= wdat[`JPO_CTRL_MODE];
      end
      if (wb_req_in.adr == `JPO_ADR_IRQ_MASK && wb_req_in.sel[0]) begin
        irq_mask_r <= wdat[`JPO_EV_W-1:0];
      end
      if (wb_req_in.adr == `JPO_ADR_HALF) begin
        half_r <= (half_r & ~wmask[`JPO_HALF_W-1:0]) | wdat[`JPO_HALF_W-1:0];
      end
    end
  end

  // abnormal flag: a fresh limit stop beats a clear in the same cycle
  assign abn_nxt = limit_stop || (abn_r && !clr_abn && !start);

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      abn_r <= 1'b0;
    end else begin
      abn_r <= abn_nxt;
    end
  end
  assign abnormal_end_flag_out = abn_r;

  // sticky events, cleared by reading them; a new event still lands
  assign events[`JPO_EV_LIMIT]   = limit_stop;
  assign events[`JPO_EV_RELEASE] = release_stop;
  assign irq_stat_nxt = ((bus_rd && wb_req_in.adr == `JPO_ADR_IRQ_STAT) ? '0 : irq_stat_r)
                        | events;

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      irq_stat_r <= '0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end
  assign irq_out = |(irq_stat_r & irq_mask_r);

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  limit_blocks_run_a: assert property (!fwd_limit_in || !rev_limit_in
                                       |=> state_r == jpo_pkg::JPO_IDLE)
    else $error("motion while a limit contact is open");
  jog_open_idle_a: assert property (!jog_fwd_in && !jog_rev_in
                                    |=> state_r == jpo_pkg::JPO_IDLE)
    else $error("motion without a held jog switch");
  fwd_start_a: assert property (state_r == jpo_pkg::JPO_IDLE && fwd_ok
                                |=> state_r == jpo_pkg::JPO_FWD && dir_r)
    else $error("forward jog did not start");
  dir_held_a: assert property (state_r == jpo_pkg::JPO_FWD && !sep_mode
                               ##1 !sep_mode |-> direction_out)
    else $error("direction low during forward jog");
  rev_quiet_fwd_a: assert property (dir_r && sep_mode |=> !direction_out)
    else $error("reverse pulse active in forward motion");
  count_up_a: assert property (step && dir_r |=> pos_r == $past(pos_r) + `JPO_POS_STEP)
    else $error("position did not advance on a forward pulse");
  count_down_a: assert property (step && !dir_r
                                 |=> pos_r == $past(pos_r) - `JPO_POS_STEP)
    else $error("position did not drop on a reverse pulse");
  // a new reverse start may legally flip direction, so only quiet stops count
  stop_dir_kept_a: assert property (release_stop && dir_r && !sep_mode
                                    ##1 (!start && !sep_mode) [*2]
                                    |-> !level ##1 direction_out)
    else $error("release did not stop pulses or lost direction");
  count_frozen_a: assert property ((state_r == jpo_pkg::JPO_IDLE) [*3]
                                   |-> $stable(pos_r))
    else $error("position moved while stopped");
  limit_stop_a: assert property (limit_stop
                                 |=> state_r == jpo_pkg::JPO_IDLE && abnormal_end_flag_out)
    else $error("limit stop not flagged");
  flag_held_a: assert property (abn_r && !clr_abn && !start |=> abn_r)
    else $error("abnormal flag dropped on its own");
  irq_level_a: assert property (irq_stat_r[`JPO_EV_LIMIT]
                                && irq_mask_r[`JPO_EV_LIMIT] |-> irq_out)
    else $error("unmasked event without interrupt");
endmodule : jpo_top
`default_nettype wire

// ---- tb/jpo_drive_model.sv ----
// drive side model that counts step pulses seen on the pulse pins
`default_nettype none
module jpo_drive_model (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        sep_mode_in,
  input  wire logic        pulse_in,
  input  wire logic        dir_in,
  output var  logic [31:0] steps_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pulse_r;
  logic dir_r;
  // one step per rising edge; the direction level only matters in pulse plus direction mode
  always @(posedge core_clk_in) begin
    pulse_r <= pulse_in;
    dir_r   <= dir_in;
    if (rst_in) begin
      steps_out <= 32'h0;
    end else if (pulse_in && !pulse_r) begin
      steps_out <= (sep_mode_in || dir_in) ? steps_out + 32'h1
                                            : steps_out - 32'h1;
    end else if (sep_mode_in && dir_in && !dir_r) begin
      steps_out <= steps_out - 32'h1;
    end
  end
endmodule : jpo_drive_model
`default_nettype wire

// ---- tb/test_jpo_top.sv ----
// self-checking bench for the jog pulse controller
`include "jpo_defs.svh"
`default_nettype none
module test_jpo_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk;
  logic                 rst;
  jpo_pkg::jpo_wb_req_t req;
  logic [31:0]          wb_dat;
  logic                 wb_ack;
  logic                 fwd_lim, rev_lim, jog_f, jog_r, sep;
  logic                 pls, dir, apls, adir, abn, irq;
  logic [31:0]          steps;
  logic [31:0]          q;
  logic [31:0]          pos0;
  int                   fail_count, tests_run, cyc_n, ha, hb, hc;

  jpo_top uut (.core_clk_in(clk), .rst_in(rst), .wb_req_in(req), .wb_dat_out(wb_dat),
    .wb_ack_out(wb_ack), .fwd_limit_in(fwd_lim), .rev_limit_in(rev_lim),
    .jog_fwd_in(jog_f), .jog_rev_in(jog_r), .pulse_train_out(pls), .direction_out(dir),
    .adapter_pulse_out(apls), .adapter_dir_out(adir), .abnormal_end_flag_out(abn),
    .irq_out(irq));
  jpo_drive_model drv (.core_clk_in(clk), .rst_in(rst), .sep_mode_in(sep), .pulse_in(pls),
    .dir_in(dir), .steps_out(steps));

  always #2.5 clk = ~clk;

  // hang guard, well above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 30000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // state word as software should read it
  function automatic logic [31:0] st_word(input logic ab, input logic busy, input logic d);
    st_word = '0;
    st_word[`JPO_ST_ABN]  = ab;
    st_word[`JPO_ST_BUSY] = busy;
    st_word[`JPO_ST_DIR]  = d;
  endfunction : st_word

  // classic single cycle; ack is read before this edge's updates land
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hf, adr: a, dat: d};
    @(posedge clk);
    // no cycle count assumed; only the hang guard ends this wait
    while (wb_ack !== 1'b1) begin
      @(posedge clk);
    end
    r = wb_dat;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  // lower word first, then the upper word
  task automatic rd_pos();
    logic [31:0] lo;
    wb(1'b0, `JPO_ADR_POS_LO, 32'h0, lo);
    wb(1'b0, `JPO_ADR_POS_HI, 32'h0, q);
    q = {q[15:0], lo[15:0]};
  endtask : rd_pos

  // hold the jog switches n cycles, dropping the forward limit at cycle lim
  task automatic jog(input logic f, input logic r, input int n, input int lim);
    ha = 0;
    hb = 0;
    hc = 0;
    jog_f <= f;
    jog_r <= r;
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (i == lim) fwd_lim <= 1'b0;
      ha += int'(pls === 1'b1);
      hb += int'(dir === 1'b1);
      hc += int'({apls, adir} !== {pls, dir});
    end
    jog_f   <= 1'b0;
    jog_r   <= 1'b0;
    fwd_lim <= 1'b1;
    repeat (6) @(posedge clk);
    chk(hc, 0);
    chk({apls, adir}, {pls, dir});
  endtask : jog

  task automatic conclude();
    $display("counts: tests_run=%0d fail_count=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  initial begin
    {clk, rst, fwd_lim, rev_lim, jog_f, jog_r, sep} = 7'b0111000;
    req = '0;
    q = $urandom(49036);
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // reset values and an unmapped place
    wb(1'b0, `JPO_ADR_HALF, 32'h0, q);
    chk(q, 32'h4);
    wb(1'b0, `JPO_ADR_STATE, 32'h0, q);
    chk(q, st_word(1'b0, 1'b0, 1'b0));
    wb(1'b0, 8'h40, 32'h0, q);
    chk(q, 32'h0);
    rd_pos();
    chk(q, 32'h0);
    $display("test reset done");
    // forward in pulse plus direction mode at a random rate
    wb(1'b1, `JPO_ADR_HALF, $urandom_range(8, 1), q);
    jog(1'b1, 1'b0, $urandom_range(80, 20), -1);
    chk(ha > 0, 1'b1);
    chk(dir, 1'b1);
    rd_pos();
    chk(q, steps);
    pos0 = q;
    chk(pos0 != 0, 1'b1);
    repeat (20) @(posedge clk);
    rd_pos();
    chk(q, pos0);
    $display("test forward pulse plus direction done");
    // separate pulse mode, reverse then forward
    wb(1'b1, `JPO_ADR_CTRL, 32'h1, q);
    sep <= 1'b1;
    jog(1'b0, 1'b1, $urandom_range(80, 20), -1);
    chk(ha, 0);
    chk(hb > 0, 1'b1);
    rd_pos();
    chk(q, steps);
    jog(1'b1, 1'b0, $urandom_range(80, 20), -1);
    chk(hb, 0);
    chk(ha > 0, 1'b1);
    rd_pos();
    chk(q, steps);
    $display("test separate pulse mode done");
    // refused starts: both jogs held, or the reverse limit hit
    jog(1'b1, 1'b1, 40, -1);
    chk(ha + hb, 0);
    rev_lim <= 1'b0;
    jog(1'b1, 1'b0, 40, -1);
    chk(ha + hb, 0);
    rev_lim <= 1'b1;
    $display("test refused starts done");
    // limit stop in mid-run; model mode changes first, else the rising
    // direction pin would look like a reverse pulse to it
    sep <= 1'b0;
    wb(1'b1, `JPO_ADR_CTRL, 32'h0, q);
    wb(1'b1, `JPO_ADR_IRQ_MASK, 32'h1, q);
    wb(1'b0, `JPO_ADR_IRQ_STAT, 32'h0, q);
    jog(1'b1, 1'b0, 60, 30);
    chk(abn, 1'b1);
    chk(irq, 1'b1);
    chk(dir, 1'b1);
    rd_pos();
    chk(q, steps);
    wb(1'b0, `JPO_ADR_STATE, 32'h0, q);
    chk(q, st_word(1'b1, 1'b0, 1'b1));
    wb(1'b0, `JPO_ADR_IRQ_STAT, 32'h0, q);
    chk(q[0], 1'b1);
    chk(irq, 1'b0);
    chk(abn, 1'b1);
    wb(1'b1, `JPO_ADR_CTRL, 32'h2, q);
    chk(abn, 1'b0);
    jog(1'b1, 1'b0, 40, 10);
    chk(abn, 1'b1);
    jog(1'b1, 1'b0, 20, -1);
    chk(abn, 1'b0);
    rd_pos();
    chk(q, steps);
    $display("test limit stop done");
    // reverse in pulse plus direction mode: count falls, direction held low
    jog(1'b0, 1'b1, $urandom_range(60, 20), -1);
    chk(ha > 0, 1'b1);
    chk(dir, 1'b0);
    rd_pos();
    chk(q, steps);
    $display("test reverse pulse plus direction done");
    conclude();
  end
endmodule : test_jpo_top
`default_nettype wire
